/* shared/psq_pkg.sv */
// Constants, state codes and carrier types of the supply sequencer.
// Assumes a single 25 MHz clock that runs while standby power is up.
package psq_pkg;

  // ==========================================================
  // Clock and timebase
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned MS_HZ  = 1_000;
  localparam int unsigned MSW    = 14;
  typedef logic [MSW-1:0] psq_ms_type;

  // ==========================================================
  // Delays in milliseconds, as printed
  localparam psq_ms_type T_PSON_ON_MIN_MS = 14'h0005; // 5
  localparam psq_ms_type T_PSON_ON_MAX_MS = 14'h0190; // 400
  localparam psq_ms_type T_PWOK_ON_MIN_MS = 14'h0064; // 100
  localparam psq_ms_type T_PWOK_OFF_MS    = 14'h0001; // 1
  localparam psq_ms_type T_PWOK_LOW_MS    = 14'h0064; // 100
  localparam psq_ms_type T_PWOK_HOLD_MS   = 14'h000C; // 12
  localparam psq_ms_type T_SB_ON_MAX_MS   = 14'h05DC; // 1500
  localparam psq_ms_type T_SB_VOUT_MS     = 14'h0032; // 50
  localparam psq_ms_type T_CLR_REQ_MS     = 14'h03E8; // 1000
  localparam psq_ms_type T_CLR_AC_MS      = 14'h3A98; // 15000

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_OFF    = 3'h0,
    ST_RAMP   = 3'h1,
    ST_PGWAIT = 3'h2,
    ST_ON     = 3'h3,
    ST_PGDROP = 3'h4,
    ST_LATCH  = 3'h5,
    ST_OTP    = 3'h6
  } psq_state_type;

  // ==========================================================
  // Sensed conditions from the analog side
  typedef struct packed {
    logic ac_ok;     // AC input above turn-on level
    logic sb_reg;    // Standby rail in regulation
    logic main_reg;  // Main rail in regulation
    logic cur_lim;   // Any output in current limit
    logic overcurrent_protection; // Main overcurrent trip
    logic overvoltage_protection; // Main overvoltage trip
    logic otp;       // Overtemperature trip
    logic temp_ok;   // Temperature back below trip minus margin
    logic temp_warn; // Temperature warning threshold
    logic fan_fail;
    logic uv;        // Undervoltage
    logic gen_fail;
    logic sb_fault;  // Standby rail protection active
  } psq_sense_type;

  // Fault record kept for nonvolatile capture
  typedef struct packed {
    logic overcurrent_protection;
    logic overvoltage_protection;
    logic otp;
    logic uv;
    logic fan_fail;
    logic gen_fail;
    logic ramp_to;   // Main rail missed its ramp deadline
  } psq_fault_type;

endpackage : psq_pkg

/* design/psq_sequencer.sv */
// On/off and fault sequencer of a redundant supply: main rail enable,
// open-drain power-good and alert, fault capture strobe.
// Assumes sense inputs already synchronous to clk_i; the request pin's
// pull-up is resolved outside, so a floating request reads high.
//
// What this block does
// - Request low enables main; high turns it off
// - Main regulation 5 to 400 ms after request
// - Power-good drops within 5 ms of release
// - Power-good rises 100 to 500 ms after regulation
// - Power-good falls 1 ms before main off on a clean turn-off
// - Power-good stays low at least 100 ms
// - Power-good held 12 ms after AC loss
// - Standby within 1500 ms of AC on
// - Main regulation at least 50 ms after standby
// - Rails rise monotonically within set ramp times
// - Trips stop main only; latch cleared by cycling
// - Overcurrent latches main off, standby self-recovers
// - Overvoltage latches main off, standby self-recovers
// - Overtemperature stops main, restarts with hysteresis
// - Power-good only while all rails regulate
// - Power-good delay paused during current limit
// - Alert asserted on faults and warnings
// - Alert together with amber indicator
// - Critical shutdown saves fault record
// - Firmware update allowed in standby
`timescale 1ns/10ps
`default_nettype none

module psq_sequencer
  import psq_pkg::*;
#(
  parameter int unsigned MS_CYC = CLK_HZ / MS_HZ
) (
  input  wire logic          clk_i,
  input  wire logic          sys_rst_i,
  input  wire logic          pwr_on_req_n_i,
  input  wire psq_sense_type sense_i,
  output logic               standby_en_o,
  output logic               main_en_o,
  output logic               pwok_o,
  output logic               pwok_oe_o,
  output logic               alert_n_o,
  output logic               alert_n_oe_o,
  output logic               amber_solid_o,
  output logic               amber_blink_o,
  output logic               nv_save_o,
  output psq_fault_type      fault_rec_o,
  output logic               fw_update_ok_o
);

  // ==========================================================
  // Elaboration check
  if (MS_CYC < 2 || MS_CYC > 32768) begin : g_bad_ms_cyc
    $error("MS_CYC must lie in 2..32768");
  end

  function automatic psq_ms_type ms_inc(input psq_ms_type c,
                                        input logic       en);
    ms_inc = (en && c != '1) ? c + psq_ms_type'(1) : c;
  endfunction : ms_inc

  // ==========================================================
  // Millisecond timebase
  logic [14:0] pre;
  logic [14:0] next_pre;
  logic        tick;

  assign tick = (pre == 15'(MS_CYC - 1));

  always_comb begin
    next_pre = tick ? 15'h0000 : pre + 15'h0001;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pre <= 15'h0000;
    end else begin
      pre <= next_pre;
    end
  end

  // ==========================================================
  // Sequencer state, timers and outputs
  psq_state_type state;
  psq_state_type next_state;
  psq_ms_type    st_ms;
  psq_ms_type    next_st_ms;
  psq_ms_type    pg_low_ms;
  psq_ms_type    next_pg_low_ms;
  psq_ms_type    sb_ms;
  psq_ms_type    next_sb_ms;
  psq_ms_type    ac_ms;
  psq_ms_type    next_ac_ms;
  psq_ms_type    clr_ms;
  psq_ms_type    next_clr_ms;
  logic          pg;
  logic          next_pg;
  logic          next_main_en;
  logic          next_sb_en;
  logic          alert;
  logic          next_alert;
  logic          next_solid;
  logic          next_blink;
  logic          next_save;
  psq_fault_type next_rec;
  logic          next_fw;
  logic          req;
  logic          trip;
  logic          ramp_to;
  logic          sb_late;
  logic          crit;
  logic          st_en;

  assign req  = !pwr_on_req_n_i;
  assign trip = sense_i.overcurrent_protection ||
                sense_i.overvoltage_protection;

  always_comb begin
    next_state = state;
    ramp_to    = 1'b0;
    unique case (state)
      ST_OFF: begin
        if (sense_i.otp) begin
          next_state = ST_OTP;
        // Main waits for a settled standby rail
        // Holdup keeps standby up after AC loss; main must not restart
        end else if (req && sense_i.ac_ok &&
                     sb_ms > T_SB_VOUT_MS) begin
          next_state = ST_RAMP;
        end
      end
      ST_RAMP: begin
        if (trip) begin
          next_state = ST_LATCH;
        end else if (sense_i.otp) begin
          next_state = ST_OTP;
        end else if (!req) begin
          next_state = ST_OFF;
        end else if (st_ms >= T_PSON_ON_MAX_MS) begin
          next_state = ST_LATCH;
          ramp_to    = 1'b1;
        end else if (sense_i.main_reg && st_ms > T_PSON_ON_MIN_MS) begin
          next_state = ST_PGWAIT;
        end
      end
      ST_PGWAIT: begin
        if (trip) begin
          next_state = ST_LATCH;
        end else if (sense_i.otp) begin
          next_state = ST_OTP;
        end else if (!req) begin
          next_state = ST_OFF;
        end else if (!sense_i.main_reg) begin
          next_state = ST_RAMP;
        end else if (st_ms > T_PWOK_ON_MIN_MS &&
                     pg_low_ms > T_PWOK_LOW_MS) begin
          next_state = ST_ON;
        end
      end
      ST_ON: begin
        if (trip) begin
          next_state = ST_LATCH;
        end else if (sense_i.otp) begin
          next_state = ST_OTP;
        end else if (!req || !sense_i.main_reg || !sense_i.sb_reg) begin
          next_state = ST_PGDROP;
        end else if (!sense_i.ac_ok && st_ms > T_PWOK_HOLD_MS) begin
          next_state = ST_PGDROP;
        end
      end
      ST_PGDROP: begin
        // Main stays up so power-good leads it down
        if (trip) begin
          next_state = ST_LATCH;
        end else if (st_ms > T_PWOK_OFF_MS) begin
          next_state = ST_OFF;
        end
      end
      ST_LATCH: begin
        if ((pwr_on_req_n_i && clr_ms > T_CLR_REQ_MS) ||
            clr_ms > T_CLR_AC_MS) begin
          next_state = ST_OFF;
        end
      end
      ST_OTP: begin
        // Separate clear input gives the restart hysteresis
        if (sense_i.temp_ok && !sense_i.otp) begin
          next_state = ST_OFF;
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase

    st_en = tick && !(state == ST_PGWAIT && sense_i.cur_lim);
    if (next_state != state || (state == ST_ON && sense_i.ac_ok)) begin
      next_st_ms = '0;
    end else begin
      next_st_ms = ms_inc(st_ms, st_en);
    end
    next_pg_low_ms = pg ? '0 : ms_inc(pg_low_ms, tick);
    next_sb_ms = sense_i.sb_reg ? ms_inc(sb_ms, tick) : '0;
    next_ac_ms = sense_i.ac_ok ? ms_inc(ac_ms, tick) : '0;
    if (state == ST_LATCH && (pwr_on_req_n_i || !sense_i.ac_ok)) begin
      next_clr_ms = ms_inc(clr_ms, tick);
    end else begin
      next_clr_ms = '0;
    end

    sb_late = !sense_i.sb_reg && ac_ms >= T_SB_ON_MAX_MS;
    next_pg = (next_state == ST_ON);
    // Enable holds steady through the ramp so the rail never steps back
    next_main_en = next_state inside {ST_RAMP, ST_PGWAIT, ST_ON,
                                      ST_PGDROP};
    // Standby only follows AC and its own protection
    next_sb_en = sense_i.ac_ok && !sense_i.sb_fault;

    crit = trip || sense_i.otp || sense_i.uv || sense_i.fan_fail ||
           sense_i.gen_fail || sb_late || next_state == ST_LATCH;
    next_alert = crit || sense_i.temp_warn;
    next_solid = crit;
    next_blink = sense_i.temp_warn && !crit;

    next_save = next_state != state &&
                next_state inside {ST_LATCH, ST_OTP};
    if (next_save) begin
      next_rec = '{overcurrent_protection: sense_i.overcurrent_protection,
                   overvoltage_protection: sense_i.overvoltage_protection,
                   otp: sense_i.otp, uv: sense_i.uv,
                   fan_fail: sense_i.fan_fail,
                   gen_fail: sense_i.gen_fail, ramp_to: ramp_to};
    end else begin
      next_rec = fault_rec_o;
    end
    next_fw = next_state == ST_OFF && sense_i.sb_reg;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state          <= ST_OFF;
      st_ms          <= '0;
      pg_low_ms      <= '0;
      sb_ms          <= '0;
      ac_ms          <= '0;
      clr_ms         <= '0;
      pg             <= 1'b0;
      main_en_o      <= 1'b0;
      standby_en_o   <= 1'b0;
      alert          <= 1'b0;
      amber_solid_o  <= 1'b0;
      amber_blink_o  <= 1'b0;
      nv_save_o      <= 1'b0;
      fault_rec_o    <= '0;
      fw_update_ok_o <= 1'b0;
    end else begin
      state          <= next_state;
      st_ms          <= next_st_ms;
      pg_low_ms      <= next_pg_low_ms;
      sb_ms          <= next_sb_ms;
      ac_ms          <= next_ac_ms;
      clr_ms         <= next_clr_ms;
      pg             <= next_pg;
      main_en_o      <= next_main_en;
      standby_en_o   <= next_sb_en;
      alert          <= next_alert;
      amber_solid_o  <= next_solid;
      amber_blink_o  <= next_blink;
      nv_save_o      <= next_save;
      fault_rec_o    <= next_rec;
      fw_update_ok_o <= next_fw;
    end
  end

  // Open-drain pins only ever pull low
  assign pwok_o       = 1'b0;
  assign pwok_oe_o    = !pg;
  assign alert_n_o    = 1'b0;
  assign alert_n_oe_o = alert;

  // ==========================================================
  // Assertions
  sequence s_ramp_done;
    state == ST_RAMP ##1 state == ST_PGWAIT;
  endsequence

  sequence s_pg_rise;
    state == ST_PGWAIT ##1 state == ST_ON;
  endsequence

  a_pg_needs_main: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    pg |-> main_en_o && state == ST_ON)
    else $error("power-good high without main rail");

  a_pg_drop_req: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    pg && pwr_on_req_n_i |=> !pg)
    else $error("power-good not dropped after release");

  a_main_off_req: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    pwr_on_req_n_i && !(state inside {ST_ON, ST_PGDROP}) |=> !main_en_o)
    else $error("main rail on while request released");

  a_ramp_needs_ac: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    state == ST_OFF && !sense_i.ac_ok |=> !main_en_o)
    else $error("main rail started without AC input");

  // A trip from the drop state cuts main at once; only a clean
  // turn-off owes the lead time
  a_pg_lead_off: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    $fell(main_en_o) && $past(state) == ST_PGDROP && state == ST_OFF
      |-> !pg && pg_low_ms > T_PWOK_OFF_MS)
    else $error("main dropped too soon after power-good");

  a_pg_low_min: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    $rose(pg) |-> $past(pg_low_ms) > T_PWOK_LOW_MS)
    else $error("power-good low time too short");

  a_pg_wait_cl: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    state == ST_PGWAIT && next_state == ST_PGWAIT && sense_i.cur_lim
      |=> $stable(st_ms))
    else $error("power-good delay ran in current limit");

  a_ramp_min: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    s_ramp_done |-> $past(st_ms) > T_PSON_ON_MIN_MS)
    else $error("main regulation accepted too early");

  a_pg_on_min: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    s_pg_rise |-> pg && $past(st_ms) > T_PWOK_ON_MIN_MS)
    else $error("power-good asserted too early");

  a_trip_latch: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    state == ST_ON && sense_i.overcurrent_protection
      |=> state == ST_LATCH && !main_en_o ##1 !pg)
    else $error("overcurrent did not latch main off");

  a_alert_amber: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    sense_i.overvoltage_protection
      |=> alert_n_oe_o && amber_solid_o && !amber_blink_o)
    else $error("alert and amber not together");

endmodule : psq_sequencer

`default_nettype wire

/* test/psq_rail_model.sv */
// Rails and board side facing the supply sequencer: rail ramps with
// holdup, the request pin with its pull-up, open-drain pin levels.
// Assumes fault flags come from the bench and enables from the design.
`timescale 1ns/10ps
`default_nettype none

module psq_rail_model
  import psq_pkg::*;
#(
  parameter int SB_CYC   = 20,
  parameter int SB_HOLD  = 700,
  parameter int MAIN_CYC = 80
) (
  input  wire logic          clk_i,
  input  wire logic          sys_rst_i,
  input  wire logic          standby_en_i,
  input  wire logic          main_en_i,
  input  wire logic          ac_ok_i,
  input  wire logic          req_pull_i,
  input  wire logic          pwok_oe_i,
  input  wire logic          alert_n_oe_i,
  input  wire psq_sense_type flags_i,
  output psq_sense_type      sense_o,
  output logic               pwr_on_req_n_o,
  output logic               pwok_pin_o,
  output logic               alert_pin_o
);
  // ==========================================================
  // Rails
  int sb_cnt;
  int main_cnt;

  // Standby charges past its level and decays slowly, which gives holdup
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sb_cnt   <= 0;
      main_cnt <= 0;
    end else begin
      if (standby_en_i)
        sb_cnt <= (sb_cnt < SB_CYC + SB_HOLD) ? sb_cnt + 1 : sb_cnt;
      else
        sb_cnt <= (sb_cnt > 0) ? sb_cnt - 1 : 0;
      if (!main_en_i)
        main_cnt <= 0;
      else if (main_cnt < MAIN_CYC)
        main_cnt <= main_cnt + 1;
    end
  end

  always_comb begin
    sense_o          = flags_i;
    sense_o.ac_ok    = ac_ok_i;
    sense_o.sb_reg   = (sb_cnt >= SB_CYC);
    sense_o.main_reg = (main_cnt == MAIN_CYC);
  end

  // ==========================================================
  // Pins with pull-ups
  assign pwr_on_req_n_o = !req_pull_i;
  assign pwok_pin_o     = !pwok_oe_i;
  assign alert_pin_o    = !alert_n_oe_i;
endmodule : psq_rail_model

`default_nettype wire

/* test/test_psq_sequencer.sv */
// Self-checking bench of the supply sequencer with a 10-cycle tick.
// Assumes the rail model stands in for the rails and the board.
`timescale 1ns/10ps
`default_nettype none

module test_psq_sequencer
  import psq_pkg::*;
;
  localparam int MS  = 10;
  localparam int LIM = 60000;
  // ==========================================================
  // Signals
  logic          clk_i     = 1'h0;
  logic          sys_rst_i = 1'h1;
  logic          req_pull  = 1'h0;
  logic          ac_ok     = 1'h1;
  psq_sense_type flags     = '0;
  psq_sense_type sense;
  psq_fault_type fault_rec;
  logic          req_n, pwok_pin, alert_pin, standby_en, main_en;
  logic          pwok, pwok_oe, alert_n, alert_n_oe, nv_save, fw_ok;
  logic          amber_solid, amber_blink;
  int            failures   = 0;
  int            num_checks = 0;
  int            cycles     = 0;

  always #20 clk_i = ~clk_i;

  psq_sequencer #(.MS_CYC(MS)) i_psq_sequencer (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .pwr_on_req_n_i(req_n),
    .sense_i(sense), .standby_en_o(standby_en), .main_en_o(main_en),
    .pwok_o(pwok), .pwok_oe_o(pwok_oe), .alert_n_o(alert_n),
    .alert_n_oe_o(alert_n_oe), .amber_solid_o(amber_solid),
    .amber_blink_o(amber_blink), .nv_save_o(nv_save),
    .fault_rec_o(fault_rec), .fw_update_ok_o(fw_ok));

  psq_rail_model #(.SB_CYC(2*MS), .SB_HOLD(70*MS), .MAIN_CYC(8*MS))
  i_psq_rail_model (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .standby_en_i(standby_en),
    .main_en_i(main_en), .ac_ok_i(ac_ok), .req_pull_i(req_pull),
    .pwok_oe_i(pwok_oe), .alert_n_oe_i(alert_n_oe), .flags_i(flags),
    .sense_o(sense), .pwr_on_req_n_o(req_n), .pwok_pin_o(pwok_pin),
    .alert_pin_o(alert_pin));

  // ==========================================================
  // Helpers
  task automatic give_verdict();
    $display("checks %0d, failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == LIM) begin
      failures++;
      give_verdict();
    end
  end

  task automatic step(input int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask : check

  function automatic logic sig(input int s);
    case (s)
      0: return pwok_pin;
      1: return main_en;
      2: return sense.main_reg;
      3: return sense.sb_reg;
      4: return nv_save;
      default: return alert_pin;
    endcase
  endfunction : sig

  // Bounded wait; the count tells how long the level took to appear
  task automatic wait_for(input int s, input logic v, input int lim,
                          output int n);
    n = 0;
    while (sig(s) !== v && n < lim) begin
      step();
      n++;
    end
  endtask : wait_for

  // ==========================================================
  // Scenarios
  task automatic turn_on(input bit first, input int cl);
    int n;
    int m;
    wait_for(3, 1'h1, 300*MS, n);
    step(2);
    check("fw ok in standby", fw_ok, 1'h1);
    req_pull = 1'h1;
    wait_for(1, 1'h1, 100*MS, n);
    wait_for(2, 1'h1, 80*MS, m);
    if (first)
      check("sb to main", 32'(n+m >= 50*MS && n+m <= 1000*MS), 1);
    check("req to main", 32'(n+m >= 5*MS && n+m <= 400*MS), 1);
    // Current limit right at regulation must hold the delay timer back
    flags.cur_lim = (cl > 0);
    if (cl > 0)
      step(cl*MS);
    flags.cur_lim = 1'h0;
    wait_for(0, 1'h1, 600*MS, n);
    check("pwok delay", 32'(n >= 100*MS && n <= 501*MS), 1);
    check("fw ok when on", fw_ok, 1'h0);
    $display("test turn_on finished");
  endtask : turn_on

  task automatic turn_off();
    int n;
    int m;
    req_pull = 1'h0;
    wait_for(0, 1'h0, 10*MS, n);
    check("pwok release", 32'(n <= 5*MS), 1);
    wait_for(1, 1'h0, 10*MS, m);
    check("pwok lead", 32'(m >= MS), 1);
    check("main off", main_en, 1'h0);
    req_pull = 1'h1;
    wait_for(0, 1'h1, 700*MS, n);
    check("pwok low time", 32'(n + m >= 100*MS), 1);
    $display("test turn_off finished");
  endtask : turn_off

  task automatic test_warn();
    int n;
    for (int i = 0; i < 8; i++) begin
      flags.temp_warn = (i == 0);
      flags.fan_fail  = (i == 2);
      flags.uv        = (i == 4);
      flags.gen_fail  = (i == 6);
      wait_for(5, i[0], 4, n);
      check("alert pin", alert_pin, i[0]);
      check("amber", {amber_solid, amber_blink},
            i[0] ? 2'h0 : (i == 0) ? 2'h1 : 2'h2);
    end
    $display("test warn finished");
  endtask : test_warn

  task automatic test_ac_loss();
    int n;
    ac_ok = 1'h0;
    wait_for(0, 1'h0, 20*MS, n);
    check("pwok holdup", 32'(n >= 12*MS), 1);
    wait_for(1, 1'h0, 5*MS, n);
    check("main off on ac loss", main_en, 1'h0);
    check("standby off", standby_en, 1'h0);
    step(80*MS);
    ac_ok = 1'h1;
    turn_on(1'h1, 30);
    $display("test ac_loss finished");
  endtask : test_ac_loss

  task automatic test_trip(input bit ov_trip);
    int n;
    flags.overcurrent_protection = !ov_trip;
    flags.overvoltage_protection = ov_trip;
    wait_for(4, 1'h1, 4, n);
    check("save strobe", nv_save, 1'h1);
    check("main trip", main_en, 1'h0);
    check("pwok trip", pwok_pin, 1'h0);
    check("standby kept", standby_en, 1'h1);
    check("alert trip", {alert_pin, amber_solid}, 2'h1);
    check("record", fault_rec, ov_trip ? 7'h20 : 7'h40);
    step();
    check("save pulse", nv_save, 1'h0);
    flags.overcurrent_protection = 1'h0;
    flags.overvoltage_protection = 1'h0;
    step(20*MS);
    check("latched", main_en, 1'h0);
    // Standby protection must clear by itself while main stays latched
    flags.sb_fault = 1'h1;
    step();
    check("standby protect", standby_en, 1'h0);
    flags.sb_fault = 1'h0;
    step();
    check("standby recover", standby_en, 1'h1);
    req_pull = 1'h0;
    step(1010*MS);
    turn_on(1'h0, 0);
    check("alert cleared", alert_pin, 1'h1);
    $display("test trip finished");
  endtask : test_trip

  task automatic test_otp();
    int n;
    flags.otp     = 1'h1;
    flags.temp_ok = 1'h0;
    wait_for(1, 1'h0, 4, n);
    check("otp off", {main_en, standby_en, pwok_pin}, 3'h2);
    step(10*MS);
    flags.otp = 1'h0;
    step(10*MS);
    check("otp hysteresis", main_en, 1'h0);
    flags.temp_ok = 1'h1;
    wait_for(1, 1'h1, 100*MS, n);
    check("otp restart", main_en, 1'h1);
    wait_for(0, 1'h1, 600*MS, n);
    check("otp pwok", pwok_pin, 1'h1);
    $display("test otp finished");
  endtask : test_otp

  initial begin
    flags.temp_ok = 1'h1;
    step(12);
    check("pwok in reset", pwok_pin, 1'h0);
    check("main in reset", main_en, 1'h0);
    check("alert in reset", alert_pin, 1'h1);
    check("pwok drive level", pwok, 1'h0);
    check("alert drive level", alert_n, 1'h0);
    sys_rst_i = 1'h0;
    turn_on(1'h1, 0);
    turn_off();
    test_warn();
    test_ac_loss();
    test_trip(1'h0);
    test_trip(1'h1);
    test_otp();
    give_verdict();
  end
endmodule : test_psq_sequencer

`default_nettype wire
